// File: rtl/uvp_pkg.sv
// uvp_pkg: constants, register map and types of the undervoltage stages
// assumes a 50 MHz ref_clk and voltages in units of 0.1 % of nominal
package uvp_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICKS_PER_S = 1_000_000 / TICK_US;
  localparam int FORCE_TIMEOUT_S = 300;
  localparam int FORCE_TICKS_DEF = FORCE_TIMEOUT_S * TICKS_PER_S;
  localparam int PREFAULT_S = 1;
  localparam int PRE_TICKS_DEF = PREFAULT_S * TICKS_PER_S;
  // ----------------------------------------------------------------
  // sizes and field values
  // ----------------------------------------------------------------
  localparam int N_STAGES = 3;
  localparam int N_GROUPS = 4;
  localparam int N_REC = 8;
  localparam int V_W = 16;
  localparam int AW = 12;
  localparam int BLK_W = 8;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [15:0] HYST_RST = 16'h001E;
  localparam logic [15:0] SCALE_RST = 16'h0001;
  localparam logic [15:0] PICK_RST = 16'h0258;
  localparam logic [15:0] DELAY_RST = 16'h03E8;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] REG_FORCE = 12'h000;
  localparam logic [AW-1:0] REG_GROUP = 12'h004;
  localparam logic [AW-1:0] REG_LVB = 12'h008;
  localparam logic [AW-1:0] REG_HYST = 12'h00C;
  localparam logic [AW-1:0] REG_REL_DLY = 12'h010;
  localparam logic [AW-1:0] REG_SCALE = 12'h014;
  localparam logic [AW-1:0] REG_VMIN = 12'h018;
  localparam logic [AW-1:0] REG_VMIN_PRI = 12'h01C;
  localparam logic [AW-1:0] REG_IRQ_STAT = 12'h020;
  localparam logic [AW-1:0] REG_IRQ_MASK = 12'h024;
  localparam logic [AW-1:0] REG_FORCE_OUT = 12'h028;
  localparam logic [AW-1:0] REG_STATUS = 12'h02C;
  localparam logic [AW-1:0] REG_CNT_CLR = 12'h030;
  localparam logic [AW-1:0] REG_REC_SEL = 12'h034;
  localparam logic [AW-1:0] REG_REC_TIME = 12'h038;
  localparam logic [AW-1:0] REG_REC_VOLT = 12'h03C;
  localparam logic [AW-1:0] REG_REC_INFO = 12'h040;
  // per stage window: base + stage * span
  localparam logic [AW-1:0] STG_BASE = 12'h080;
  localparam logic [AW-1:0] STG_SPAN = 12'h040;
  localparam logic [5:0] STG_BLK_MASK = 6'h00;
  localparam logic [5:0] STG_START_CNT = 6'h04;
  localparam logic [5:0] STG_TRIP_CNT = 6'h08;
  localparam logic [5:0] STG_PICK_PRI = 6'h0C;
  localparam logic [5:0] STG_PICK = 6'h10;
  localparam logic [5:0] STG_DELAY = 6'h20;
  // ----------------------------------------------------------------
  // group selection source
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GSRC_NONE = 3'b000,
    GSRC_DIGITAL = 3'b001,
    GSRC_VIRTUAL = 3'b010,
    GSRC_INDICATOR = 3'b011,
    GSRC_VOUT = 3'b100,
    GSRC_FKEY = 3'b101
  } uvp_grp_src_t;
endpackage

// File: rtl/uvp_top.sv
// uvp_top: three definite-time undervoltage stages with register port
// assumes voltage inputs synchronous to ref_clk, refreshed by the front end
//
// Summary of operation
// RL1: start when lowest line voltage below pick-up
// RL2: trip when start outlasts operate delay
// RL3: block matrix suppresses any stage
// RL4: self-block while highest voltage below limit
// RL5: block limit zero disables self-blocking
// RL6: software keeps limit sensible for short delays
// RL7: three independent definite-time stages
// RL8: four setting groups, active one selectable
// RL9: group source none, input, output or key
// RL10: status blocked/start/trip, writable under force; only start and trip are forced, blocked is not
// RL11: shared force flag clears after five minutes
// RL12: start and trip counters, clearable
// RL13: release delay on first stage only
// RL14: eight latest fault records per stage
// RL15: record minimum voltage and elapsed delay percent
// RL16: record one-second prefault average voltage
// RL17: report minimum voltage and pick-up in primary volts
// RL18: release above pick-up plus hysteresis, reset timer
// RL19: evaluation on periodic measurement tick
`timescale 1ns/1ps
module uvp_top import uvp_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int FORCE_TICKS = FORCE_TICKS_DEF,
  parameter int PRE_TICKS = PRE_TICKS_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [V_W-1:0] v12,
  input wire logic [V_W-1:0] v23,
  input wire logic [V_W-1:0] v31,
  input wire logic [BLK_W-1:0] block_in,
  input wire logic [1:0] digital_input_n,
  input wire logic [1:0] virtual_input_n,
  input wire logic [1:0] indicator_signal_n,
  input wire logic [1:0] virtual_output_n,
  input wire logic [1:0] function_key_n,
  input wire logic [31:0] time_stamp,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic [N_STAGES-1:0] start_out,
  output logic [N_STAGES-1:0] trip_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 2 || FORCE_TICKS < 1 || PRE_TICKS < 1 || PRE_TICKS > 1048575) begin : g_bad
    $error("uvp_top: tick, force or prefault count out of range");
  end

  // ----------------------------------------------------------------
  // measurement tick
  // ----------------------------------------------------------------
  logic [31:0] div_r;
  logic tick_r;
  // RL19 tick divider
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= (div_r == 32'(TICK_CYCLES - 1)) ? '0 : div_r + 32'h1;
      tick_r <= (div_r == 32'(TICK_CYCLES - 1));
    end
  end

  // ----------------------------------------------------------------
  // voltage extremes
  // ----------------------------------------------------------------
  wire [V_W-1:0] min_ab = (v12 < v23) ? v12 : v23;
  wire [V_W-1:0] vmin = (min_ab < v31) ? min_ab : v31;
  wire [V_W-1:0] max_ab = (v12 > v23) ? v12 : v23;
  wire [V_W-1:0] vmax = (max_ab > v31) ? max_ab : v31;

  // ----------------------------------------------------------------
  // common registers and decode
  // ----------------------------------------------------------------
  logic force_r;
  logic [31:0] force_cnt_r;
  logic [1:0] man_grp_r;
  uvp_grp_src_t gsrc_r;
  logic [15:0] lvb_r, hyst_r, rel_dly_r, scale_r;
  logic [2*N_STAGES-1:0] irq_stat_r, irq_mask_r;
  logic [N_STAGES-1:0] frc_start_r, frc_trip_r;
  logic [1:0] rec_stage_r;
  logic [2:0] rec_idx_r;
  logic [39:0] pre_sum_r;
  logic [19:0] pre_cnt_r;
  logic [V_W-1:0] pre_avg_r;

  wire w_force = wr_en && addr == REG_FORCE;
  wire w_group = wr_en && addr == REG_GROUP;
  wire w_lvb = wr_en && addr == REG_LVB;
  wire w_hyst = wr_en && addr == REG_HYST;
  wire w_rel = wr_en && addr == REG_REL_DLY;
  wire w_scale = wr_en && addr == REG_SCALE;
  wire w_istat = wr_en && addr == REG_IRQ_STAT;
  wire w_imask = wr_en && addr == REG_IRQ_MASK;
  // RL10 forced status only accepted while force is on
  wire w_frc = wr_en && addr == REG_FORCE_OUT && force_r;
  wire w_clr = wr_en && addr == REG_CNT_CLR;
  wire w_rsel = wr_en && addr == REG_REC_SEL;
  wire force_expire = force_r && tick_r && force_cnt_r == 32'(FORCE_TICKS - 1);

  // RL8 RL9 active group from the chosen source or the manual setting
  logic [1:0] grp_src_val;
  always_comb begin
    unique case (gsrc_r)
      GSRC_DIGITAL: grp_src_val = digital_input_n;
      GSRC_VIRTUAL: grp_src_val = virtual_input_n;
      GSRC_INDICATOR: grp_src_val = indicator_signal_n;
      GSRC_VOUT: grp_src_val = virtual_output_n;
      GSRC_FKEY: grp_src_val = function_key_n;
      default: grp_src_val = man_grp_r;
    endcase
  end
  wire [1:0] grp = grp_src_val;

  // RL11 shared force flag with timeout
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      force_r <= 1'b0;
      force_cnt_r <= '0;
    end else if (w_force) begin
      force_r <= wr_data[0];
      force_cnt_r <= '0;
    end else if (force_expire) begin
      force_r <= 1'b0;
      force_cnt_r <= '0;
    end else if (force_r && tick_r) begin
      force_cnt_r <= force_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      man_grp_r <= 2'h0;
      gsrc_r <= GSRC_NONE;
      lvb_r <= '0;
      hyst_r <= HYST_RST;
      rel_dly_r <= '0;
      scale_r <= SCALE_RST;
      irq_mask_r <= '0;
      rec_stage_r <= 2'h0;
      rec_idx_r <= 3'h0;
    end else begin
      if (w_group) begin
        man_grp_r <= wr_data[1:0];
        gsrc_r <= uvp_grp_src_t'(wr_data[6:4]);
      end
      if (w_lvb) lvb_r <= wr_data[15:0];
      if (w_hyst) hyst_r <= wr_data[15:0];
      if (w_rel) rel_dly_r <= wr_data[15:0];
      if (w_scale) scale_r <= wr_data[15:0];
      if (w_imask) irq_mask_r <= wr_data[2*N_STAGES-1:0];
      if (w_rsel) begin
        rec_stage_r <= wr_data[1:0];
        rec_idx_r <= wr_data[6:4];
      end
    end
  end

  // RL10 forced outputs drop with the flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frc_start_r <= '0;
      frc_trip_r <= '0;
    end else if (!force_r) begin
      frc_start_r <= '0;
      frc_trip_r <= '0;
    end else if (w_frc) begin
      frc_start_r <= wr_data[N_STAGES-1:0];
      frc_trip_r <= wr_data[4+N_STAGES-1:4];
    end
  end

  // RL16 one-second block average of the supervised voltage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_sum_r <= '0;
      pre_cnt_r <= '0;
      pre_avg_r <= '0;
    end else if (tick_r) begin
      if (pre_cnt_r == 20'(PRE_TICKS - 1)) begin
        pre_avg_r <= V_W'((pre_sum_r + 40'(vmin)) / 40'(PRE_TICKS));
        pre_sum_r <= '0;
        pre_cnt_r <= '0;
      end else begin
        pre_sum_r <= pre_sum_r + 40'(vmin);
        pre_cnt_r <= pre_cnt_r + 20'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [N_STAGES-1:0] start_r, trip_r, blocked_w, start_rise, trip_rise;
  logic [31:0] stg_rd [N_STAGES];
  logic [31:0] rec_time_w [N_STAGES];
  logic [31:0] rec_volt_w [N_STAGES];
  logic [31:0] rec_info_w [N_STAGES];
  logic [N_STAGES-1:0] stg_hit;

  genvar s;
  for (s = 0; s < N_STAGES; s++) begin : g_stg
    localparam logic [AW-1:0] BASE = AW'(STG_BASE + AW'(s) * STG_SPAN);
    logic [15:0] pick_r [N_GROUPS];
    logic [15:0] dly_r [N_GROUPS];
    logic [BLK_W-1:0] bmask_r;
    logic [31:0] scnt_r, tcnt_r;
    logic [15:0] tmr_r, rel_r;
    logic [16:0] pct_acc_r;
    logic [6:0] pct_r;
    logic [V_W-1:0] fmin_r, fpre_r;
    logic [31:0] ftime_r;
    logic [1:0] fgrp_r;
    logic [31:0] rt_r [N_REC];
    logic [V_W-1:0] rmin_r [N_REC];
    logic [V_W-1:0] rpre_r [N_REC];
    logic [6:0] rpct_r [N_REC];
    logic [1:0] rgrp_r [N_REC];
    logic [2:0] wptr_r;

    wire hit = (addr & ~(STG_SPAN - 12'h001)) == BASE;
    wire [5:0] off = addr[5:0];
    wire [15:0] pick = pick_r[grp];
    wire [15:0] dly = dly_r[grp];
    // RL1 undervoltage below the active pick-up
    wire under = vmin < pick;
    // RL18 release above pick-up plus dead band, or at once when blocked
    wire over = {1'b0, vmin} > ({1'b0, pick} + {1'b0, hyst_r});
    // RL4 RL5 self-block, disabled by a zero limit
    wire self_blk = (lvb_r != 16'h0000) && (vmax < lvb_r);
    // RL3 block matrix
    wire ext_blk = |(block_in & bmask_r);
    wire blk = self_blk | ext_blk;
    // RL13 release delay on the first stage only
    wire rel_done = (s != 0) || (rel_r >= rel_dly_r);
    wire release_now = start_r[s] && (blk || (over && rel_done));
    wire begin_now = !start_r[s] && under && !blk;
    // RL2 trip once the delay has elapsed
    wire trip_now = start_r[s] && !release_now && !trip_r[s] && (tmr_r >= dly);
    wire [16:0] acc_nxt = pct_acc_r + 17'(PCT_FULL);
    wire [2:0] rd_slot = 3'(wptr_r - 3'h1 - rec_idx_r);

    assign stg_hit[s] = hit;
    assign blocked_w[s] = blk;
    assign start_rise[s] = tick_r && begin_now;
    assign trip_rise[s] = tick_r && trip_now;

    // RL7 RL8 per-stage pick-up and delay in four groups, one block mask for all groups
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        for (int g = 0; g < N_GROUPS; g++) begin
          pick_r[g] <= PICK_RST;
          dly_r[g] <= DELAY_RST;
        end
        bmask_r <= '0;
      end else if (wr_en && hit) begin
        if (off == STG_BLK_MASK) bmask_r <= wr_data[BLK_W-1:0];
        if (off[5:4] == STG_PICK[5:4]) pick_r[off[3:2]] <= wr_data[15:0];
        if (off[5:4] == STG_DELAY[5:4]) dly_r[off[3:2]] <= wr_data[15:0];
      end
    end

    // RL1 RL2 RL18 RL19 start/trip state updated on the tick
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        start_r[s] <= 1'b0;
        trip_r[s] <= 1'b0;
        tmr_r <= '0;
        rel_r <= '0;
      end else if (tick_r) begin
        if (begin_now) begin
          start_r[s] <= 1'b1;
          tmr_r <= 16'h0001;
        end else if (release_now) begin
          start_r[s] <= 1'b0;
          trip_r[s] <= 1'b0;
          tmr_r <= '0;
        end else if (start_r[s]) begin
          if (trip_now) trip_r[s] <= 1'b1;
          if (tmr_r != 16'hFFFF) tmr_r <= tmr_r + 16'h1;
        end
        rel_r <= (start_r[s] && over && !rel_done) ? rel_r + 16'h1 : '0;
      end
    end

    // RL12 event counters, clear by writing a one
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        scnt_r <= '0;
        tcnt_r <= '0;
      end else begin
        if (start_rise[s]) scnt_r <= scnt_r + 32'h1;
        else if (w_clr && wr_data[s]) scnt_r <= '0;
        if (trip_rise[s]) tcnt_r <= tcnt_r + 32'h1;
        else if (w_clr && wr_data[4+s]) tcnt_r <= '0;
      end
    end

    // RL15 running fault minimum and elapsed percentage
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        pct_acc_r <= '0;
        pct_r <= '0;
        fmin_r <= '0;
        fpre_r <= '0;
        ftime_r <= '0;
        fgrp_r <= 2'h0;
      end else if (tick_r) begin
        if (begin_now) begin
          pct_acc_r <= '0;
          pct_r <= '0;
          fmin_r <= vmin;
          fpre_r <= pre_avg_r;
          ftime_r <= time_stamp;
          fgrp_r <= grp;
        end else if (start_r[s] && !release_now) begin
          if (vmin < fmin_r) fmin_r <= vmin;
          if (trip_now || trip_r[s]) begin
            pct_r <= PCT_FULL;
          end else if (acc_nxt >= {1'b0, dly}) begin
            pct_acc_r <= acc_nxt - {1'b0, dly};
            if (pct_r < PCT_FULL) pct_r <= pct_r + 7'h01;
          end else begin
            pct_acc_r <= acc_nxt;
          end
        end
      end
    end

    // RL14 ring of the latest faults, written when the fault ends
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        wptr_r <= 3'h0;
        for (int i = 0; i < N_REC; i++) begin
          rt_r[i] <= '0;
          rmin_r[i] <= '0;
          rpre_r[i] <= '0;
          rpct_r[i] <= '0;
          rgrp_r[i] <= 2'h0;
        end
      end else if (tick_r && release_now) begin
        rt_r[wptr_r] <= ftime_r;
        rmin_r[wptr_r] <= fmin_r;
        // RL16 average taken before the fault began
        rpre_r[wptr_r] <= fpre_r;
        rpct_r[wptr_r] <= pct_r;
        rgrp_r[wptr_r] <= fgrp_r;
        wptr_r <= wptr_r + 3'h1;
      end
    end

    assign rec_time_w[s] = rt_r[rd_slot];
    assign rec_volt_w[s] = {rpre_r[rd_slot], rmin_r[rd_slot]};
    assign rec_info_w[s] = {22'h0, 3'(rgrp_r[rd_slot]) + 3'h1, rpct_r[rd_slot]};

    // RL17 pick-up in primary volts
    wire [31:0] pick_pri = pick * scale_r;
    always_comb begin
      stg_rd[s] = 32'h0;
      if (off == STG_BLK_MASK) stg_rd[s] = 32'(bmask_r);
      if (off == STG_START_CNT) stg_rd[s] = scnt_r;
      if (off == STG_TRIP_CNT) stg_rd[s] = tcnt_r;
      if (off == STG_PICK_PRI) stg_rd[s] = pick_pri;
      if (off[5:4] == STG_PICK[5:4]) stg_rd[s] = 32'(pick_r[off[3:2]]);
      if (off[5:4] == STG_DELAY[5:4]) stg_rd[s] = 32'(dly_r[off[3:2]]);
    end
  end

  // ----------------------------------------------------------------
  // interrupts and outputs
  // ----------------------------------------------------------------
  wire [2*N_STAGES-1:0] irq_ev = {trip_rise, start_rise};
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_r <= '0;
    end else begin
      // a new event wins over a simultaneous clear
      irq_stat_r <= (irq_stat_r & ~({2*N_STAGES{w_istat}} & wr_data[2*N_STAGES-1:0])) | irq_ev;
    end
  end

  // RL10 forced values override the stage outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      start_out <= '0;
      trip_out <= '0;
      irq <= 1'b0;
    end else begin
      start_out <= force_r ? frc_start_r : start_r;
      trip_out <= force_r ? frc_trip_r : trip_r;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // read mux, data one cycle after the strobe
  // ----------------------------------------------------------------
  // RL17 minimum voltage in primary volts
  wire [31:0] vmin_pri = vmin * scale_r;
  wire [N_STAGES-1:0] stat_start = force_r ? frc_start_r : start_r;
  wire [N_STAGES-1:0] stat_trip = force_r ? frc_trip_r : trip_r;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (addr)
      REG_FORCE: rd_mux = {31'h0, force_r};
      REG_GROUP: rd_mux = {21'h0, 3'(grp) + 3'h1, 1'b0, gsrc_r, 2'h0, man_grp_r};
      REG_LVB: rd_mux = {16'h0, lvb_r};
      REG_HYST: rd_mux = {16'h0, hyst_r};
      REG_REL_DLY: rd_mux = {16'h0, rel_dly_r};
      REG_SCALE: rd_mux = {16'h0, scale_r};
      REG_VMIN: rd_mux = {16'h0, vmin};
      REG_VMIN_PRI: rd_mux = vmin_pri;
      REG_IRQ_STAT: rd_mux = 32'(irq_stat_r);
      REG_IRQ_MASK: rd_mux = 32'(irq_mask_r);
      REG_FORCE_OUT: rd_mux = {25'h0, frc_trip_r, 1'b0, frc_start_r};
      REG_STATUS: rd_mux = {21'h0, stat_trip, 1'b0, stat_start, 1'b0, blocked_w};
      REG_REC_SEL: rd_mux = {25'h0, rec_idx_r, 2'h0, rec_stage_r};
      REG_REC_TIME: rd_mux = (rec_stage_r < 2'h3) ? rec_time_w[rec_stage_r] : 32'h0;
      REG_REC_VOLT: rd_mux = (rec_stage_r < 2'h3) ? rec_volt_w[rec_stage_r] : 32'h0;
      REG_REC_INFO: rd_mux = (rec_stage_r < 2'h3) ? rec_info_w[rec_stage_r] : 32'h0;
      default: begin
        for (int i = 0; i < N_STAGES; i++) begin
          if (stg_hit[i]) rd_mux = stg_rd[i];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rd_data <= '0;
    else if (rd_en) rd_data <= rd_mux;
    else rd_data <= '0;
  end
endmodule // uvp_top

// File: testbench/uvp_meas_model.sv
// uvp_meas_model: measurement front end feeding three line voltages
// assumes levels from the bench, refreshed on every rising ref_clk edge
`timescale 1ns/1ps
module uvp_meas_model import uvp_pkg::*; (
  input wire logic ref_clk,
  input wire logic [V_W-1:0] lvl_low,
  input wire logic [V_W-1:0] lvl_high,
  output logic [V_W-1:0] v12,
  output logic [V_W-1:0] v23,
  output logic [V_W-1:0] v31
);
  logic [1:0] rot_r = 2'h0;
  always @(posedge ref_clk) begin
    rot_r <= (rot_r == 2'h2) ? 2'h0 : rot_r + 2'h1;
    v12 <= (rot_r == 2'h0) ? lvl_low : lvl_high;
    v23 <= (rot_r == 2'h1) ? lvl_low : lvl_high;
    v31 <= (rot_r == 2'h2) ? lvl_low : lvl_high;
  end
endmodule // uvp_meas_model

// File: testbench/uvp_top_asserts.sv
// uvp_top_asserts: port-level checks of the undervoltage stages
// assumes binding to uvp_top running with a short measurement tick
`timescale 1ns/1ps
module uvp_chk import uvp_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic [N_STAGES-1:0] start_out,
  input wire logic [N_STAGES-1:0] trip_out,
  input wire logic irq
);
  logic [5:0] out_q_r;
  logic [2:0] evt_r;
  logic [2:0] wr_r;
  wire [5:0] outs = {trip_out, start_out};
  wire evt = wr_en || (outs != out_q_r);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_q_r <= 6'h00;
      evt_r <= 3'h0;
      wr_r <= 3'h0;
    end else begin
      out_q_r <= outs;
      evt_r <= {evt_r[1:0], evt};
      wr_r <= {wr_r[1:0], wr_en};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence quiet_s; (outs == 6'h00 && !irq)[*8]; endsequence
  sequence hold_s; ($stable(outs) || wr_r != 3'h0)[*8]; endsequence
  rd_idle_zero_a:
    assert property (!rd_en |=> rd_data == 32'h0) else $error("read data not zero outside read");
  trip_has_start_a:
    assert property ((trip_out & ~start_out) == 3'h0) else $error("trip without start");
  reset_quiet_a:
    assert property ($rose(nrst) |-> quiet_s) else $error("outputs active before first tick");
  out_tick_hold_a:
    assert property ($changed(outs) |=> hold_s) else $error("outputs changed between ticks");
  trip_after_start_a:
    assert property ($rose(trip_out[0]) && wr_r == 3'h0 |-> $past(start_out[0], 9)) else $error("trip too early");
  trip_fall_start_a:
    assert property ($fell(trip_out[0]) && wr_r == 3'h0 |-> !start_out[0]) else $error("trip fell alone");
  irq_rise_cause_a:
    assert property ($rose(irq) |-> evt || evt_r != 3'h0) else $error("interrupt rose without event");
  irq_fall_cause_a:
    assert property ($fell(irq) |-> wr_r != 3'h0) else $error("interrupt fell without write");
endmodule // uvp_chk
bind uvp_top uvp_chk uvp_chk_i (.ref_clk, .nrst, .wr_en, .rd_en, .rd_data, .start_out, .trip_out, .irq);

// File: testbench/tb_uvp_top.sv
// tb_uvp_top: self-checking bench of the undervoltage stages
// assumes a 50 MHz clock, a 10-cycle tick and a 20-tick force timeout
`timescale 1ns/1ps
module tb_uvp_top;
  import uvp_pkg::*;
  localparam int TC = 10;
  localparam logic [15:0] ROW_V [7] = '{16'h03E8, 16'h0316, 16'h032A, 16'h0257, 16'h018F, 16'h01B8, 16'h03E8};
  localparam logic [2:0] ROW_S [7] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h7, 3'h3, 3'h0};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [V_W-1:0] lvl_low = 16'h03E8;
  logic [V_W-1:0] lvl_high = 16'h03E8;
  logic [BLK_W-1:0] block_in = 8'h00;
  logic [1:0] grp_in [5] = '{default: 2'h0};
  logic [31:0] time_stamp = 32'h12345678;
  logic [AW-1:0] addr = 12'h000;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic [2:0] start_out;
  logic [2:0] trip_out;
  logic irq;
  logic [V_W-1:0] v12;
  logic [V_W-1:0] v23;
  logic [V_W-1:0] v31;
  logic [31:0] rv;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  uvp_meas_model uvp_meas_model_i (.ref_clk, .lvl_low, .lvl_high, .v12, .v23, .v31);
  uvp_top #(.TICK_CYCLES(TC), .FORCE_TICKS(20), .PRE_TICKS(4)) uvp_top_i (
    .ref_clk, .nrst, .v12, .v23, .v31, .block_in, .digital_input_n(grp_in[0]), .virtual_input_n(grp_in[1]),
    .indicator_signal_n(grp_in[2]), .virtual_output_n(grp_in[3]), .function_key_n(grp_in[4]), .time_stamp,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .start_out, .trip_out, .irq);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    rv = rd_data;
    chk_reg(rv, exp);
    @(posedge ref_clk);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
    chk_reg({29'h0, got}, {29'h0, exp});
  endtask
  task automatic ticks(input int k);
    repeat (k * TC) @(posedge ref_clk);
  endtask
  function automatic logic [AW-1:0] sa(input int s, input logic [5:0] off);
    return STG_BASE + AW'(s) * STG_SPAN + {6'h00, off};
  endfunction
  task automatic summarize;
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rdchk(sa(1, STG_PICK), {16'h0, PICK_RST});
    rdchk(REG_HYST, {16'h0, HYST_RST});
    for (int s = 0; s < 3; s++) begin
      wr(sa(s, STG_PICK), 32'h320 - 32'(s) * 32'hC8);
      wr(sa(s, STG_DELAY), 32'hC8);
    end
    wr(REG_SCALE, 32'h2);
    for (int i = 0; i < 7; i++) begin
      lvl_low <= ROW_V[i];
      ticks(3);
      chk_pin(start_out, ROW_S[i]);
      rdchk(REG_VMIN_PRI, {15'h0, ROW_V[i], 1'b0});
    end
    wr(REG_LVB, 32'h96);
    lvl_low <= 16'h0064;
    lvl_high <= 16'h0064;
    ticks(3);
    chk_pin(start_out, 3'h0);
    wr(REG_LVB, 32'h0);
    ticks(3);
    chk_pin(start_out, 3'h7);
    lvl_high <= 16'h03E8;
    lvl_low <= 16'h018F;
    wr(sa(2, STG_BLK_MASK), 32'h1);
    block_in <= 8'h01;
    ticks(3);
    chk_pin(start_out, 3'h3);
    lvl_low <= 16'h03E8;
    block_in <= 8'h00;
    for (int g = 1; g < 4; g++) wr(sa(1, STG_PICK) + 12'(4 * g), 32'h384);
    for (int src = 1; src < 6; src++) begin
      for (int k = 0; k < 5; k++) grp_in[k] <= (k == src - 1) ? 2'h1 : 2'h2;
      wr(REG_GROUP, 32'(src) << 4);
      rdchk(REG_GROUP, {21'h0, 3'h2, 1'b0, 3'(src), 4'h0});
    end
    wr(REG_GROUP, 32'h3);
    rdchk(REG_GROUP, 32'h403);
    wr(REG_GROUP, 32'h10);
    lvl_low <= 16'h0352;
    ticks(3);
    chk_pin(start_out, 3'h2);
    lvl_low <= 16'h03E8;
    wr(REG_GROUP, 32'h0);
    wr(REG_CNT_CLR, 32'h77);
    rdchk(sa(0, STG_START_CNT), 32'h0);
    wr(sa(0, STG_DELAY), 32'h3);
    wr(REG_IRQ_STAT, 32'h3F);
    wr(REG_IRQ_MASK, 32'h1);
    ticks(10);
    lvl_low <= 16'h02BC;
    n = 0;
    while (start_out[0] !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (trip_out[0] !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk_reg(32'(n), 32'h1E);
    chk_pin({2'h0, irq}, 3'h1);
    rdchk(REG_STATUS, 32'h110);
    wr(REG_IRQ_STAT, 32'h3F);
    repeat (3) @(posedge ref_clk);
    chk_pin({2'h0, irq}, 3'h0);
    lvl_low <= 16'h03E8;
    ticks(3);
    rdchk(sa(0, STG_START_CNT), 32'h1);
    rdchk(sa(0, STG_TRIP_CNT), 32'h1);
    wr(REG_REC_SEL, 32'h0);
    rdchk(REG_REC_TIME, 32'h12345678);
    rdchk(REG_REC_VOLT, 32'h03E802BC);
    rdchk(REG_REC_INFO, 32'hE4);
    wr(REG_REL_DLY, 32'h5);
    lvl_low <= 16'h01F4;
    ticks(3);
    lvl_low <= 16'h03E8;
    ticks(3);
    chk_pin(start_out, 3'h1);
    ticks(5);
    chk_pin(start_out, 3'h0);
    wr(REG_FORCE_OUT, 32'h11);
    rdchk(REG_STATUS, 32'h0);
    wr(REG_FORCE, 32'h1);
    wr(REG_FORCE_OUT, 32'h11);
    repeat (3) @(posedge ref_clk);
    chk_pin(trip_out, 3'h1);
    ticks(22);
    chk_pin(start_out, 3'h0);
    rdchk(REG_FORCE, 32'h0);
    rdchk(12'hFFC, 32'h0);
    lvl_low <= 16'h01F4;
    ticks(3);
    nrst <= 1'b0;
    @(posedge ref_clk);
    chk_pin(start_out, 3'h0);
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    rdchk(sa(0, STG_DELAY), {16'h0, DELAY_RST});
    rdchk(REG_LVB, 32'h0);
    ticks(3);
    chk_pin(start_out, 3'h7);
    summarize();
  end
endmodule // tb_uvp_top
